// file: sqdiag_ctrl.v
// squib loop diagnostic control: measurement, fet, gnd loss, timer test
`timescale 1ns/1ps
`include "sqdiag_map.vh"
module sqdiag_ctrl #(
   parameter NCH       = 4,
   parameter FETTO_CYC = `SQD_FETTO_US * `SQD_CLK_MHZ,
   parameter IDLE_CYC  = `SQD_IDLE_US * `SQD_CLK_MHZ,
   parameter GLF_CYC   = `SQD_GLFILT_US * `SQD_CLK_MHZ
) (
   input  wire           CORE_CLK_IN,
   input  wire           RESETN_IN,
   input  wire [3:0]     ADDR_IN,
   input  wire [31:0]    WDATA_IN,
   input  wire           WR_IN,
   input  wire           RD_IN,
   output reg  [31:0]    RDATA_OUT,
   input  wire           DIAG_STATE_IN,
   input  wire           ADC_VALID_IN,
   input  wire [9:0]     ADC_DATA_IN,
   input  wire           CMP_HIGH_RES_UPPER_FLAG_IN,
   input  wire           CMP_HIGH_RES_LOWER_FLAG_IN,
   input  wire           CMP_STB_IN,
   input  wire           CMP_STG_IN,
   input  wire           GND_DROP_IN,
   output reg            SRC_EN_OUT,
   output reg            SNK_EN_OUT,
   output reg            SRC_TO_RET_OUT,
   output reg            MON_EN_OUT,
   output reg  [NCH-1:0] PULLDOWN_EN_OUT,
   output reg  [1:0]     CH_SEL_OUT,
   output reg            ADC_REQ_OUT,
   output reg  [2:0]     ADC_SEL_OUT,
   output reg  [NCH-1:0] HS_DRV_OUT,
   output reg  [NCH-1:0] LS_DRV_OUT,
   output reg            SAFE_REG_EN_OUT,
   output reg            TIMER_PROBE_OUT
);
   localparam TW = 20;
   localparam [TW-1:0] FET_T  = FETTO_CYC;
   localparam [TW-1:0] IDLE_T = IDLE_CYC;
   localparam [TW-1:0] GLF_T  = GLF_CYC;
   localparam [TW-1:0] DEF_T  = `SQD_DEFPULSE_US * `SQD_CLK_MHZ;
   // one-hot states of the test sequencer
   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_FET  = 5'h02;
   localparam [4:0] S_TGAP = 5'h04;
   localparam [4:0] S_TPUL = 5'h08;
   localparam [4:0] S_HLV  = 5'h10;

   wire [7:0] cmp_s;
   wire       diag_s;
   wire       high_res_upper_flag;
   wire       high_res_lower_flag;
   wire       stb_s;
   wire       stg_s;
   wire       gdrop_s;
   wire       adcv_s;
   wire [9:0] adcd_s;
   wire       t_busy;
   wire       t_done;
   wire       g_busy;
   wire       g_done;

   reg [15:0]     lreq_r;
   reg            autooff_r;
   reg [2:0]      stest_r;
   reg [2:0]      creq_r;
   reg [9:0]      cres_r;
   reg            cres_new_r;
   reg [NCH-1:0]  gloss_r;
   reg            stb_lat_r;
   reg            stg_lat_r;
   reg            fet_on_r;
   reg            fet_hs_r;
   reg [4:0]      st_r;
   reg [1:0]      tch_r;
   reg [TW-1:0]   dep_r [0:NCH-1];
   reg [NCH-1:0]  dep_set_r;
   reg            t_load;
   reg [TW-1:0]   t_cnt;
   reg            g_arm;
   integer        i, j, k;

   // comparator and analog inputs cross from the analog domain
   sqdiag_sync #(.W(8)) u_sync (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (RESETN_IN),
      .d_in     ({CMP_HIGH_RES_UPPER_FLAG_IN, CMP_HIGH_RES_LOWER_FLAG_IN, CMP_STB_IN, CMP_STG_IN,
                  GND_DROP_IN, DIAG_STATE_IN, ADC_VALID_IN, 1'b0}),
      .q_out    (cmp_s)
   );
   assign high_res_upper_flag  = cmp_s[7];
   assign high_res_lower_flag  = cmp_s[6];
   assign stb_s   = cmp_s[5];
   assign stg_s   = cmp_s[4];
   assign gdrop_s = cmp_s[3];
   assign diag_s  = cmp_s[2];
   assign adcv_s  = cmp_s[1];

   // data held stable by the converter until valid; two stages for safety
   sqdiag_sync #(.W(10)) u_sdat (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (RESETN_IN),
      .d_in     (ADC_DATA_IN),
      .q_out    (adcd_s)
   );

   // shared timer for fet timeout, idle gaps and timer pulses
   sqdiag_timer #(.W(TW)) u_tmr (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (RESETN_IN),
      .load_in  (t_load),
      .stop_in  (1'b0),
      .count_in (t_cnt),
      .busy_out (t_busy),
      .done_out (t_done)
   );

   // ground loss filter restarts whenever the drop disappears
   sqdiag_timer #(.W(TW)) u_glf (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (RESETN_IN),
      .load_in  (g_arm & ~g_busy),
      .stop_in  (~g_arm),
      .count_in (GLF_T),
      .busy_out (g_busy),
      .done_out (g_done)
   );

   wire wr_lreq = WR_IN && (ADDR_IN == `SQD_A_LOOPREQ);
   wire wr_sys  = WR_IN && (ADDR_IN == `SQD_A_SYSDIAG);
   wire [2:0] scode = WDATA_IN[2:0];
   wire [1:0] lk_ch = lreq_r[`SQD_LR_LK_LO+1:`SQD_LR_LK_LO];
   wire [1:0] ms_ch = lreq_r[`SQD_LR_CH_LO+1:`SQD_LR_CH_LO];
   wire       meas  = lreq_r[`SQD_LR_SRC] & lreq_r[`SQD_LR_SNK];
   wire       res_rd = RD_IN && (ADDR_IN == `SQD_A_CONVRES);

   always @* begin
      g_arm = gdrop_s & (meas | (fet_on_r & fet_hs_r));
   end

   // sequencer timer load decode
   always @* begin
      t_load = 1'b0;
      t_cnt  = {TW{1'b0}};
      if (st_r == S_IDLE && wr_sys && diag_s &&
          (scode == `SQD_ST_HSFET || scode == `SQD_ST_LSFET)) begin
         t_load = 1'b1;
         t_cnt  = FET_T;
      end else if (st_r == S_IDLE && wr_sys && diag_s &&
                   scode == `SQD_ST_TIMER) begin
         t_load = 1'b1;
         t_cnt  = IDLE_T;
      end else if (st_r == S_TGAP && t_done) begin
         t_load = 1'b1;
         t_cnt  = dep_set_r[tch_r] ? dep_r[tch_r] : DEF_T;
      end else if (st_r == S_TPUL && t_done && tch_r != NCH - 1) begin
         t_load = 1'b1;
         t_cnt  = IDLE_T;
      end else if (st_r == S_IDLE && wr_lreq &&
                   WDATA_IN[`SQD_LR_HLGO]) begin
         t_load = 1'b1;
         t_cnt  = FET_T;
      end
   end

   // register writes, test sequencing and flag latching
   always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         lreq_r     <= `SQD_LR_RST;
         autooff_r  <= 1'b0;
         stest_r    <= `SQD_ST_NONE;
         creq_r     <= 3'h0;
         st_r       <= S_IDLE;
         tch_r      <= 2'h0;
         fet_on_r   <= 1'b0;
         fet_hs_r   <= 1'b0;
         stb_lat_r  <= 1'b0;
         stg_lat_r  <= 1'b0;
         dep_set_r  <= {NCH{1'b0}};
         SAFE_REG_EN_OUT <= 1'b0;
         TIMER_PROBE_OUT <= 1'b0;
         for (i = 0; i < NCH; i = i + 1) begin
            dep_r[i] <= {TW{1'b0}};
         end
      end else begin
         if (wr_lreq) begin
            lreq_r <= WDATA_IN[15:0];
         end
         // auto switch-off after the result is read
         if (res_rd && autooff_r && cres_new_r) begin
            lreq_r[`SQD_LR_SRC] <= 1'b0;
            lreq_r[`SQD_LR_SNK] <= 1'b0;
         end
         if (WR_IN && ADDR_IN == `SQD_A_SYSCFG) begin
            autooff_r <= WDATA_IN[`SQD_CFG_AUTOOFF];
         end
         if (WR_IN && ADDR_IN >= `SQD_A_DEPCFG0) begin
            dep_r[ADDR_IN[1:0]]     <= WDATA_IN[TW-1:0];
            dep_set_r[ADDR_IN[1:0]] <= 1'b1;
         end
         // flags cleared only by a new request command
         if (wr_lreq || wr_sys) begin
            stb_lat_r <= 1'b0;
            stg_lat_r <= 1'b0;
         end
         // leaving diagnostic state drops the safing supply
         if (!diag_s) begin
            SAFE_REG_EN_OUT <= 1'b0;
         end
         TIMER_PROBE_OUT <= (st_r == S_TPUL) && !t_done;
         case (st_r)
            S_IDLE: begin
               // system tests accepted only in diagnostic state
               if (wr_sys && diag_s) begin
                  stest_r <= scode;
                  if (scode == `SQD_ST_HSFET || scode == `SQD_ST_LSFET) begin
                     // flags already cleared above on this write
                     fet_on_r <= 1'b1;
                     fet_hs_r <= (scode == `SQD_ST_HSFET);
                     st_r     <= S_FET;
                  end else if (scode == `SQD_ST_SAFE) begin
                     SAFE_REG_EN_OUT <= 1'b1;
                  end else if (scode == `SQD_ST_TIMER) begin
                     tch_r <= 2'h0;
                     st_r  <= S_TGAP;
                  end else begin
                     SAFE_REG_EN_OUT <= 1'b0;
                  end
               end else if (wr_lreq && WDATA_IN[`SQD_LR_HLGO]) begin
                  // high-level run of the selected test
                  st_r <= S_HLV;
               end
            end
            S_FET: begin
               // stop on threshold or on timeout
               if ((fet_hs_r && stb_s) || (!fet_hs_r && stg_s) ||
                   t_done || !diag_s) begin
                  fet_on_r  <= 1'b0;
                  // result pair latched at the stop
                  stb_lat_r <= stb_s;
                  stg_lat_r <= stg_s;
                  st_r      <= S_IDLE;
               end
            end
            S_TGAP: begin
               // idle gap before each channel pulse
               if (t_done) begin
                  st_r <= S_TPUL;
               end
            end
            S_TPUL: begin
               if (t_done) begin
                  if (tch_r == NCH - 1) begin
                     st_r <= S_IDLE;
                  end else begin
                     tch_r <= tch_r + 2'h1;
                     st_r  <= S_TGAP;
                  end
               end
            end
            S_HLV: begin
               // monitor runs for the window, then comparators are kept
               if (t_done) begin
                  stb_lat_r <= stb_s;
                  stg_lat_r <= stg_s;
                  st_r      <= S_IDLE;
               end
            end
            default: begin
               st_r <= S_IDLE;
            end
         endcase
         if (WR_IN && ADDR_IN == `SQD_A_DIAGCTL) begin
            creq_r <= WDATA_IN[2:0];
         end
      end
   end

   // conversion request pulse and atomic result capture
   always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         ADC_REQ_OUT <= 1'b0;
         ADC_SEL_OUT <= 3'h0;
         cres_r      <= 10'h000;
         cres_new_r  <= 1'b0;
      end else begin
         ADC_REQ_OUT <= WR_IN && (ADDR_IN == `SQD_A_DIAGCTL);
         if (WR_IN && ADDR_IN == `SQD_A_DIAGCTL) begin
            ADC_SEL_OUT <= WDATA_IN[2:0];
         end
         // whole 10-bit word replaced at once; set wins
         if (adcv_s) begin
            cres_r     <= adcd_s;
            cres_new_r <= 1'b1;
         end else if (res_rd) begin
            cres_new_r <= 1'b0;
         end
      end
   end

   // ground loss latched after filter, read clears, set wins
   always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         gloss_r <= {NCH{1'b0}};
      end else begin
         for (j = 0; j < NCH; j = j + 1) begin
            if (g_done && j == (meas ? ms_ch : lk_ch)) begin
               gloss_r[j] <= 1'b1;
            end else if (RD_IN && ADDR_IN == `SQD_A_GNDLOSS) begin
               gloss_r[j] <= 1'b0;
            end
         end
      end
   end

   // analog switch and driver controls from request bits
   always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         SRC_EN_OUT      <= 1'b0;
         SNK_EN_OUT      <= 1'b0;
         SRC_TO_RET_OUT  <= 1'b0;
         MON_EN_OUT      <= 1'b0;
         PULLDOWN_EN_OUT <= {NCH{1'b1}};
         CH_SEL_OUT      <= 2'h0;
         HS_DRV_OUT      <= {NCH{1'b0}};
         LS_DRV_OUT      <= {NCH{1'b0}};
      end else begin
         // source and sink on the chosen channel
         SRC_EN_OUT <= lreq_r[`SQD_LR_SRC];
         SNK_EN_OUT <= lreq_r[`SQD_LR_SNK] | lreq_r[`SQD_LR_HSR];
         SRC_TO_RET_OUT <= lreq_r[`SQD_LR_BYPASS];
         // high resistance test uses monitor with sink
         MON_EN_OUT <= lreq_r[`SQD_LR_MON] | lreq_r[`SQD_LR_HSR] |
                       (st_r == S_HLV);
         CH_SEL_OUT <= (lreq_r[`SQD_LR_MON] || fet_on_r) ? lk_ch : ms_ch;
         // pulldown bit clear disables every return pulldown
         for (k = 0; k < NCH; k = k + 1) begin
            PULLDOWN_EN_OUT[k] <= lreq_r[`SQD_LR_PD] &&
               !(lreq_r[`SQD_LR_MON] && k == lk_ch);
            // drivers only while the fet test runs
            HS_DRV_OUT[k] <= fet_on_r && fet_hs_r && k == lk_ch;
            LS_DRV_OUT[k] <= fet_on_r && !fet_hs_r && k == lk_ch;
         end
      end
   end

   // register read data, one cycle after the strobe
   always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         RDATA_OUT <= 32'h00000000;
      end else if (RD_IN) begin
         case (ADDR_IN)
            `SQD_A_LOOPREQ:  RDATA_OUT <= {16'h0000, lreq_r};
            // live and latched flags, channel and pin under test
            `SQD_A_LOOPSTAT: RDATA_OUT <= {18'h00000, st_r, t_busy,
               lreq_r[`SQD_LR_PIN], lk_ch, fet_on_r, stg_lat_r,
               stb_lat_r, high_res_lower_flag, high_res_upper_flag};
            `SQD_A_SYSCFG:   RDATA_OUT <= {31'h00000000, autooff_r};
            `SQD_A_SYSDIAG:  RDATA_OUT <= {29'h00000000, stest_r};
            `SQD_A_DIAGCTL:  RDATA_OUT <= {29'h00000000, creq_r};
            `SQD_A_CONVRES:  RDATA_OUT <= {21'h000000, cres_new_r, cres_r};
            `SQD_A_GNDLOSS:  RDATA_OUT <= {{(32-NCH){1'b0}}, gloss_r};
            default: begin
               if (ADDR_IN >= `SQD_A_DEPCFG0) begin
                  RDATA_OUT <= {{(32-TW){1'b0}}, dep_r[ADDR_IN[1:0]]};
               end else begin
                  RDATA_OUT <= 32'h00000000;
               end
            end
         endcase
      end else begin
         RDATA_OUT <= 32'h00000000;
      end
   end
endmodule

// file: sqdiag_map.vh
// register offsets, field positions, reset values and timing counts
`ifndef SQDIAG_MAP_VH
`define SQDIAG_MAP_VH
// register addresses (word index on the plain port)
`define SQD_A_LOOPREQ   4'h0
`define SQD_A_LOOPSTAT  4'h1
`define SQD_A_SYSCFG    4'h2
`define SQD_A_SYSDIAG   4'h3
`define SQD_A_DIAGCTL   4'h4
`define SQD_A_CONVRES   4'h5
`define SQD_A_GNDLOSS   4'h6
`define SQD_A_DEPCFG0   4'h8
// loop request fields
`define SQD_LR_SRC      0
`define SQD_LR_SNK      1
`define SQD_LR_BYPASS   2
`define SQD_LR_MON      3
`define SQD_LR_PD       4
`define SQD_LR_PIN      5
`define SQD_LR_HSR      6
`define SQD_LR_HLGO     7
`define SQD_LR_CH_LO    8
`define SQD_LR_LK_LO    10
`define SQD_LR_TSEL_LO  12
`define SQD_LR_RST      16'h0010
// system test codes
`define SQD_ST_NONE     3'h0
`define SQD_ST_HSFET    3'h1
`define SQD_ST_LSFET    3'h2
`define SQD_ST_SAFE     3'h3
`define SQD_ST_TIMER    3'h4
// conversion request codes
`define SQD_CR_MEAS1    3'h1
`define SQD_CR_MEAS2    3'h2
`define SQD_CR_SAFREG   3'h3
`define SQD_CR_SAFNODE  3'h4
// system config
`define SQD_CFG_AUTOOFF 0
// timing, microseconds
`define SQD_FETTO_US    500
`define SQD_GLFILT_US   100
`define SQD_IDLE_US     8000
`define SQD_DEFPULSE_US 8
`define SQD_CLK_MHZ     50
`endif

// file: sqdiag_sync.v
// two flip-flop synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
module sqdiag_sync #(
   parameter W = 1
) (
   input  wire         clk_in,
   input  wire         rst_n_in,
   input  wire [W-1:0] d_in,
   output wire [W-1:0] q_out
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   // first stage feeds only the second
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
      end else begin
         s1_r <= d_in;
         s2_r <= s1_r;
      end
   end
   assign q_out = s2_r;
endmodule

// file: sqdiag_timer.v
// down counter giving a done pulse after a loaded number of cycles
`timescale 1ns/1ps
module sqdiag_timer #(
   parameter W = 20
) (
   input  wire         clk_in,
   input  wire         rst_n_in,
   input  wire         load_in,
   input  wire         stop_in,
   input  wire [W-1:0] count_in,
   output wire         busy_out,
   output reg          done_out
);
   reg [W-1:0] cnt_r;
   // load wins over a running count; done is one cycle
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_r    <= {W{1'b0}};
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (load_in) begin
            cnt_r <= count_in;
         end else if (stop_in) begin
            cnt_r <= {W{1'b0}};
         end else if (cnt_r != {W{1'b0}}) begin
            cnt_r <= cnt_r - 1'b1;
            if (cnt_r == {{(W-1){1'b0}}, 1'b1}) begin
               done_out <= 1'b1;
            end
         end
      end
   end
   assign busy_out = (cnt_r != {W{1'b0}});
endmodule

// file: sqdiag_ctrl_sva.sv
// port-level checker for the squib loop diagnostic control block
`timescale 1ns/1ps
module sqdiag_ctrl_sva #(
   parameter NCH       = 4,
   parameter FETTO_CYC = 50,
   parameter IDLE_CYC  = 200
) (
   input wire logic           CORE_CLK_IN,
   input wire logic           RESETN_IN,
   input wire logic [3:0]     ADDR_IN,
   input wire logic [31:0]    WDATA_IN,
   input wire logic           WR_IN,
   input wire logic           RD_IN,
   input wire logic [31:0]    RDATA_OUT,
   input wire logic           DIAG_STATE_IN,
   input wire logic           CMP_STB_IN,
   input wire logic           SRC_EN_OUT,
   input wire logic [NCH-1:0] PULLDOWN_EN_OUT,
   input wire logic           ADC_REQ_OUT,
   input wire logic [2:0]     ADC_SEL_OUT,
   input wire logic [NCH-1:0] HS_DRV_OUT,
   input wire logic [NCH-1:0] LS_DRV_OUT,
   input wire logic           SAFE_REG_EN_OUT,
   input wire logic           TIMER_PROBE_OUT
);
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   logic [19:0] on_cnt_r;
   logic [19:0] low_cnt_r;
   // driver on time and probe idle time; idle count saturates
   always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         on_cnt_r  <= 20'h0;
         low_cnt_r <= 20'h0;
      end else begin
         on_cnt_r  <= (|{HS_DRV_OUT, LS_DRV_OUT}) ? on_cnt_r + 20'h1 : 20'h0;
         if (TIMER_PROBE_OUT)
            low_cnt_r <= 20'h0;
         else if (low_cnt_r != 20'hfffff)
            low_cnt_r <= low_cnt_r + 20'h1;
      end
   end
   rdata_idle_a: assert property (
      !$past(RD_IN) |-> RDATA_OUT == 32'h0) else $error("stray read data");
   adc_launch_a: assert property (
      WR_IN && ADDR_IN == 4'h4 |=> ADC_REQ_OUT &&
      ADC_SEL_OUT == $past(WDATA_IN[2:0])) else $error("conversion not asked");
   adc_pulse_a: assert property (
      ADC_REQ_OUT |=> !ADC_REQ_OUT) else $error("conversion pulse too long");
   src_follow_a: assert property (
      WR_IN && ADDR_IN == 4'h0 |-> ##2 SRC_EN_OUT == $past(WDATA_IN[0], 2))
      else $error("source enable wrong");
   pd_all_off_a: assert property (
      WR_IN && ADDR_IN == 4'h0 && !WDATA_IN[4] |-> ##2 PULLDOWN_EN_OUT == '0)
      else $error("pulldowns left on");
   fet_time_a: assert property (
      on_cnt_r <= FETTO_CYC + 2) else $error("driver on past timeout");
   fet_stop_a: assert property (
      (|HS_DRV_OUT) && CMP_STB_IN |-> ##[1:5] HS_DRV_OUT == '0)
      else $error("driver not stopped at threshold");
   probe_gap_a: assert property (
      $rose(TIMER_PROBE_OUT) |-> low_cnt_r >= IDLE_CYC - 1)
      else $error("timer idle gap short");
   diag_off_a: assert property (
      !DIAG_STATE_IN [*6] |=> !SAFE_REG_EN_OUT && HS_DRV_OUT == '0 &&
      LS_DRV_OUT == '0) else $error("test left on outside diag state");
endmodule

// file: sqdiag_afe_model.sv
// converter and current comparator front end facing the diagnostic block
`timescale 1ns/1ps
module sqdiag_afe_model (
   input  wire logic       clk_in,
   input  wire logic       adc_req_in,
   input  wire logic [2:0] adc_sel_in,
   input  wire logic [3:0] hs_drv_in,
   input  wire logic [3:0] ls_drv_in,
   input  wire logic       fet_dead_in,
   output logic            adc_valid_out,
   output logic [9:0]      adc_data_out,
   output logic            cmp_stb_out,
   output logic            cmp_stg_out
);
   logic [7:0] hs_sr;
   logic [7:0] ls_sr;
   logic [3:0] wait_r;
   logic [2:0] sel_r;
   initial begin
      {adc_valid_out, adc_data_out, cmp_stb_out, cmp_stg_out} = 13'h0;
      {hs_sr, ls_sr, wait_r, sel_r} = 23'h0;
   end
   // monitor current trips a while after a good driver turns on
   always @(posedge clk_in) begin
      hs_sr <= {hs_sr[6:0], (|hs_drv_in) & !fet_dead_in};
      ls_sr <= {ls_sr[6:0], (|ls_drv_in) & !fet_dead_in};
      cmp_stb_out <= hs_sr[7] & (|hs_drv_in);
      cmp_stg_out <= ls_sr[7] & (|ls_drv_in);
   end
   // data settles a cycle before valid, then turns to junk
   always @(posedge clk_in) begin
      if (adc_req_in) begin
         wait_r <= 4'h1;
         sel_r  <= adc_sel_in;
      end else if (wait_r == 4'hc)
         wait_r <= 4'h0;
      else if (wait_r != 4'h0)
         wait_r <= wait_r + 4'h1;
      if (wait_r == 4'h5)
         adc_data_out <= 10'h2a5 ^ {7'h0, sel_r};
      else if (wait_r == 4'ha)
         adc_data_out <= ~adc_data_out;
      adc_valid_out <= wait_r == 4'h6 || wait_r == 4'h7;
   end
endmodule

// file: sqdiag_ctrl_test.sv
// self-checking bench for the squib loop diagnostic control block
`timescale 1ns/1ps
`include "sqdiag_map.vh"
module sqdiag_ctrl_test;
   localparam FETTO = 50;
   localparam IDLE  = 200;
   logic        clk, rst_n, wr, rd, diag, high_res_upper_flag, high_res_lower_flag, gnd_drop, fet_dead;
   logic [3:0]  addr;
   logic [31:0] wdata;
   wire  [31:0] rdata;
   wire         adc_valid, stb, ground_short_flag, src_en, snk_en, src_ret, mon_en;
   wire         adc_req, safe_en, probe;
   wire  [9:0]  adc_data;
   wire  [3:0]  pd_en, hs_drv, ls_drv;
   wire  [2:0]  adc_sel;
   wire  [1:0]  ch_sel;
   integer      err_total, cmp_count, cyc;

   sqdiag_ctrl #(.FETTO_CYC(FETTO), .IDLE_CYC(IDLE), .GLF_CYC(20)) dut_u (
      .CORE_CLK_IN(clk), .RESETN_IN(rst_n), .ADDR_IN(addr),
      .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
      .DIAG_STATE_IN(diag), .ADC_VALID_IN(adc_valid), .ADC_DATA_IN(adc_data),
      .CMP_HIGH_RES_UPPER_FLAG_IN(high_res_upper_flag), .CMP_HIGH_RES_LOWER_FLAG_IN(high_res_lower_flag), .CMP_STB_IN(stb),
      .CMP_STG_IN(ground_short_flag), .GND_DROP_IN(gnd_drop), .SRC_EN_OUT(src_en),
      .SNK_EN_OUT(snk_en), .SRC_TO_RET_OUT(src_ret), .MON_EN_OUT(mon_en),
      .PULLDOWN_EN_OUT(pd_en), .CH_SEL_OUT(ch_sel), .ADC_REQ_OUT(adc_req),
      .ADC_SEL_OUT(adc_sel), .HS_DRV_OUT(hs_drv), .LS_DRV_OUT(ls_drv),
      .SAFE_REG_EN_OUT(safe_en), .TIMER_PROBE_OUT(probe));
   sqdiag_afe_model afe_u (.clk_in(clk), .adc_req_in(adc_req),
      .adc_sel_in(adc_sel), .hs_drv_in(hs_drv), .ls_drv_in(ls_drv),
      .fet_dead_in(fet_dead), .adc_valid_out(adc_valid),
      .adc_data_out(adc_data), .cmp_stb_out(stb), .cmp_stg_out(ground_short_flag));

   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // bus cycles: one strobe cycle, a free edge before the next one
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'h1;
      @(posedge clk);
      wr    <= 1'h0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] q);
      @(posedge clk);
      addr <= a;
      rd   <= 1'h1;
      @(posedge clk);
      rd   <= 1'h0;
      #1;
      q = rdata;
   endtask
   // conversion request, then poll until a fresh result shows
   task automatic conv(input logic [2:0] code);
      logic [31:0] q;
      int n;
      wr_reg(`SQD_A_DIAGCTL, {29'h0, code});
      q = 32'h0;
      for (n = 0; n < 30 && q[10] !== 1'h1; n++)
         rd_reg(`SQD_A_CONVRES, q);
      chk("result", q, {21'h1, 10'h2a5 ^ {7'h0, code}});
   endtask
   task automatic t_reset;
      logic [31:0] q;
      chk("pd rst", {28'h0, pd_en}, 32'hf);
      rd_reg(`SQD_A_LOOPREQ, q);
      chk("lreq rst", q, 32'h10);
      wr_reg(4'h7, 32'hffff);
      rd_reg(4'h7, q);
      chk("unmapped", q, 32'h0);
   endtask
   task automatic t_meas;
      wr_reg(`SQD_A_SYSCFG, 32'h1);
      wr_reg(`SQD_A_LOOPREQ, 32'h213);
      step(2);
      chk("step1", {27'h0, src_en, snk_en, src_ret, ch_sel}, 32'h1a);
      conv(`SQD_CR_MEAS1);
      step(3);
      chk("auto off", {30'h0, src_en, snk_en}, 32'h0);
      wr_reg(`SQD_A_LOOPREQ, 32'h217);
      step(2);
      chk("bypass", {29'h0, src_en, snk_en, src_ret}, 32'h7);
      conv(`SQD_CR_MEAS2);
      wr_reg(`SQD_A_LOOPREQ, 32'h0);
      step(2);
      chk("pd off", {28'h0, pd_en}, 32'h0);
   endtask
   task automatic t_stat;
      logic [31:0] q;
      wr_reg(`SQD_A_LOOPREQ, 32'hc30);
      @(posedge clk);
      high_res_upper_flag <= 1'h1;
      step(5);
      rd_reg(`SQD_A_LOOPSTAT, q);
      chk("leak pin", {27'h0, q[7:5], q[1:0]}, 32'h1d);
      high_res_upper_flag <= 1'h0;
      high_res_lower_flag <= 1'h1;
      step(5);
      rd_reg(`SQD_A_LOOPSTAT, q);
      chk("hsr live", {30'h0, q[1:0]}, 32'h2);
   endtask
   // one driver test on leak channel 1, judged on timing and flags
   task automatic fet_run(input logic [2:0] code, input logic dead,
                          input logic [2:0] exp);
      logic [31:0] q;
      int n;
      @(posedge clk);
      fet_dead <= dead;
      wr_reg(`SQD_A_SYSDIAG, {29'h0, code});
      for (n = 0; n < 10 && (hs_drv | ls_drv) === 4'h0; n++)
         step(1);
      chk("drv", {23'h0, mon_en, hs_drv, ls_drv},
          code == 3'h1 ? 32'h120 : 32'h102);
      rd_reg(`SQD_A_LOOPSTAT, q);
      chk("active", {31'h0, q[4]}, 32'h1);
      for (n = 0; n < 100 && (hs_drv | ls_drv) !== 4'h0; n++)
         step(1);
      chk("on time", {31'h0, dead ? n >= FETTO - 10 : n <= 16}, 32'h1);
      rd_reg(`SQD_A_LOOPSTAT, q);
      chk("flags", {29'h0, q[4:2]}, {29'h0, exp});
   endtask
   task automatic t_fet;
      logic [31:0] q;
      wr_reg(`SQD_A_LOOPREQ, 32'h418);
      fet_run(`SQD_ST_HSFET, 1'h0, 3'h1);
      fet_run(`SQD_ST_LSFET, 1'h1, 3'h0);
      fet_run(`SQD_ST_LSFET, 1'h0, 3'h2);
      wr_reg(`SQD_A_LOOPREQ, 32'h498);
      rd_reg(`SQD_A_LOOPSTAT, q);
      chk("flag clr", {25'h0, q[13:9], q[3:2]}, 32'h40);
      step(FETTO);
   endtask
   task automatic t_safe;
      wr_reg(`SQD_A_SYSDIAG, {29'h0, `SQD_ST_SAFE});
      step(4);
      chk("safe on", {31'h0, safe_en}, 32'h1);
      conv(`SQD_CR_SAFREG);
      conv(`SQD_CR_SAFNODE);
      wr_reg(`SQD_A_SYSDIAG, {29'h0, `SQD_ST_NONE});
      step(4);
      chk("safe off", {31'h0, safe_en}, 32'h0);
   endtask
   task automatic t_nodiag;
      @(posedge clk);
      diag <= 1'h0;
      step(4);
      wr_reg(`SQD_A_SYSDIAG, {29'h0, `SQD_ST_HSFET});
      wr_reg(`SQD_A_SYSDIAG, {29'h0, `SQD_ST_SAFE});
      wr_reg(`SQD_A_SYSDIAG, {29'h0, `SQD_ST_TIMER});
      step(IDLE + 50);
      chk("no diag", {26'h0, hs_drv, safe_en, probe}, 32'h0);
      diag <= 1'h1;
      step(4);
   endtask
   task automatic t_gnd;
      logic [31:0] q;
      wr_reg(`SQD_A_LOOPREQ, 32'h313);
      gnd_drop <= 1'h1;
      step(10);
      gnd_drop <= 1'h0;
      rd_reg(`SQD_A_GNDLOSS, q);
      chk("glitch", q, 32'h0);
      gnd_drop <= 1'h1;
      step(40);
      gnd_drop <= 1'h0;
      rd_reg(`SQD_A_GNDLOSS, q);
      chk("gnd lost", q, 32'h8);
      rd_reg(`SQD_A_GNDLOSS, q);
      chk("read clr", q, 32'h0);
   endtask
   task automatic t_timer;
      int c, n, m;
      wr_reg(`SQD_A_DEPCFG0 + 4'h1, 32'h64);
      wr_reg(`SQD_A_SYSDIAG, {29'h0, `SQD_ST_TIMER});
      for (c = 0; c < 4; c++) begin
         for (n = 0; n < IDLE + 30 && probe !== 1'h1; n++)
            step(1);
         for (m = 0; m < 500 && probe === 1'h1; m++)
            step(1);
         chk("pulse", m, c == 1 ? 32'h64 : 32'h190);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ceiling well above the few thousand cycles the tests take
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         report_and_stop;
      end
   end
   initial begin
      {rst_n, wr, rd, high_res_upper_flag, high_res_lower_flag, gnd_drop, fet_dead} = 7'h0;
      {addr, wdata} = 36'h0;
      diag = 1'h1;
      {err_total, cmp_count, cyc} = 96'h0;
      repeat (16) @(posedge clk);
      rst_n <= 1'h1;
      step(2);
      t_reset;
      t_meas;
      t_stat;
      t_fet;
      t_safe;
      t_nodiag;
      t_gnd;
      t_timer;
      report_and_stop;
   end
endmodule

bind sqdiag_ctrl sqdiag_ctrl_sva #(.NCH(NCH), .FETTO_CYC(FETTO_CYC),
   .IDLE_CYC(IDLE_CYC)) chk_u (.CORE_CLK_IN(CORE_CLK_IN),
   .RESETN_IN(RESETN_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
   .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
   .DIAG_STATE_IN(DIAG_STATE_IN), .CMP_STB_IN(CMP_STB_IN),
   .SRC_EN_OUT(SRC_EN_OUT), .PULLDOWN_EN_OUT(PULLDOWN_EN_OUT),
   .ADC_REQ_OUT(ADC_REQ_OUT), .ADC_SEL_OUT(ADC_SEL_OUT),
   .HS_DRV_OUT(HS_DRV_OUT), .LS_DRV_OUT(LS_DRV_OUT),
   .SAFE_REG_EN_OUT(SAFE_REG_EN_OUT), .TIMER_PROBE_OUT(TIMER_PROBE_OUT));
